// >>> design/upstream_ais_alarm_monitor.sv
// upstream ais detection on both drop buses with alarm latching, interrupts and apb registers
`timescale 1ns/1ps
`default_nettype none
module upstream_ais_alarm_monitor (
   input wire logic ref_clk_in, // 40 mhz system clock
   input wire logic rst_n_in, // async reset, active low
   input wire logic psel_in, // apb select
   input wire logic penable_in, // apb enable
   input wire logic pwrite_in, // apb direction
   input wire logic [11:0] paddr_in, // apb byte address
   input wire logic [31:0] pwdata_in, // apb write data
   output logic [31:0] prdata_out, // apb read data
   output logic pready_out, // apb ready
   output logic pslverr_out, // apb error on unmapped address
   input wire logic [1:0][7:0] drop_data_in, // drop bus bytes, [0]=a [1]=b
   input wire logic [1:0] drop_valid_in, // byte present on each drop bus
   input wire logic [1:0] drop_c1_in, // c1 byte marker of each drop bus
   input wire logic [3:0] rx_fifo_error_in, // per-port alarm levels
   input wire logic [3:0] tx_fifo_a_error_in, // per-port alarm levels
   input wire logic [3:0] tx_fifo_b_error_in, // per-port alarm levels
   input wire logic [3:0] tributary_signal_loss_in, // per-port alarm levels
   input wire logic [3:0] tributary_clock_loss_in, // per-port alarm levels
   input wire logic [3:0] tributary_drop_ais_in, // per-port alarm levels
   input wire logic [3:0] a_rfi_in, // side a remote failure per port
   input wire logic [3:0] b_rfi_in, // side b remote failure per port
   output logic [2:0] a_bus_upstream_ais_out, // current a bus ais per signal
   output logic [2:0] b_bus_upstream_ais_out, // current b bus ais per signal
   output logic irq_out // hardware interrupt, active high level
);
   localparam int NA = ais_alarm_pkg::NALM;

   typedef struct packed {
      logic [1:0][7:0] bus_d1;
      logic [1:0][7:0] bus_d2;
      logic [1:0] c1_d1;
      logic [1:0] c1_d2;
      logic [1:0] val_d1;
      logic [1:0] val_d2;
      logic [1:0][11:0] pos;
      logic [1:0][2:0][7:0] h1_hold;
      logic [1:0][2:0] ais;
      logic [1:0][2:0][1:0] set_cnt;
      logic [1:0][2:0][1:0] clr_cnt;
      logic [NA-1:0] prev;
      logic [NA-1:0] latch;
      logic [NA-1:0] clr_sel;
      logic [1:0] fmt;
      logic transition_latch_enable;
      logic rise;
      logic fall;
      logic remote_fail_irq_enable;
      logic aisen;
      logic owsel;
      logic hwie;
      logic [3:0] rx_msk;
      logic [3:0] tp_msk;
      logic [3:0] ta_msk;
      logic [3:0] tb_msk;
      logic [3:0] port_msk;
      logic [2:0] a_ais_msk;
      logic [2:0] b_ais_msk;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } state_s;

   state_s r;
   state_s next_r;

   // byte address of a register index
   function automatic logic [11:0] reg_addr(input logic [7:0] idx);
      reg_addr = {2'h0, idx, 2'h0};
   endfunction

   // count of ones in a byte
   function automatic logic [3:0] ones_of(input logic [7:0] b);
      logic [3:0] c;
      c = 4'h0;
      for (int i = 0; i < 8; i++) begin
         c = c + {3'h0, b[i]};
      end
      ones_of = c;
   endfunction

   // new data flag nibble counts as normal, single-bit errors included
   function automatic logic ndf_normal(input logic [3:0] n);
      ndf_normal = (n == 4'h6) || (n == 4'he) || (n == 4'h2) || (n == 4'h4) || (n == 4'h7);
   endfunction

   // which alarm changes count as events under the latching policy
   function automatic logic [NA-1:0] event_hits(input logic [NA-1:0] now,
         input logic [NA-1:0] prev, input logic transition_latch_enable, input logic rise, input logic fall);
      logic [NA-1:0] h;
      h = now;
      if (transition_latch_enable) begin
         h = '0;
         if (rise) begin
            h = h | (now & ~prev);
         end
         if (fall) begin
            h = h | (~now & prev);
         end
      end
      event_hits = h;
   endfunction

   logic [NA-1:0] alarm_now;
   logic [6:0] sw_ind;

   // gather every alarm source into one vector
   assign alarm_now = {b_rfi_in, a_rfi_in, r.ais[1], r.ais[0], tributary_drop_ais_in,
                       tributary_clock_loss_in, tributary_signal_loss_in,
                       tx_fifo_b_error_in, tx_fifo_a_error_in, rx_fifo_error_in};

   // software interrupt indications from latched events and masks
   always_comb begin
      for (int p = 0; p < ais_alarm_pkg::PORTS; p++) begin
         sw_ind[p] = r.port_msk[p] & ((r.latch[p] & r.rx_msk[p])
            | (r.latch[4 + p] & r.ta_msk[p])
            | (r.latch[8 + p] & r.tb_msk[p])
            | ((r.latch[12 + p] | r.latch[16 + p] | r.latch[20 + p]) & r.tp_msk[p]));
      end
      sw_ind[4] = |(r.latch[ais_alarm_pkg::AIS_BASE +: 3] & r.a_ais_msk);
      sw_ind[5] = |(r.latch[ais_alarm_pkg::AIS_BASE + 3 +: 3] & r.b_ais_msk);
      sw_ind[6] = r.remote_fail_irq_enable & (|r.latch[ais_alarm_pkg::RFI_BASE +: 8]);
   end

   // next state: bus sampling, ais detectors, alarm latching and register access
   always_comb begin
      logic [11:0] cp;
      logic [11:0] e1o;
      logic [11:0] h1o;
      logic [11:0] h2g;
      logic [11:0] chn;
      int nch;
      logic [7:0] byt;
      logic setup;
      logic access;
      logic hit;
      logic [7:0] wd;
      cp = 12'h000;
      e1o = ais_alarm_pkg::STS3_E1_OFS;
      h1o = ais_alarm_pkg::STS3_H1_OFS;
      h2g = ais_alarm_pkg::STS3_H2_GAP;
      chn = 12'h000;
      nch = 1;
      byt = 8'h00;
      hit = 1'b0;
      wd = pwdata_in[7:0];
      setup = psel_in & ~penable_in;
      access = psel_in & penable_in & r.pready;
      next_r = r;

      // drop bus pins pass two flops first
      next_r.bus_d1 = drop_data_in;
      next_r.bus_d2 = r.bus_d1;
      next_r.c1_d1 = drop_c1_in;
      next_r.c1_d2 = r.c1_d1;
      next_r.val_d1 = drop_valid_in;
      next_r.val_d2 = r.val_d1;

      // format picks offsets and number of watched positions
      if (r.fmt == ais_alarm_pkg::FMT_STS1) begin
         e1o = ais_alarm_pkg::STS1_E1_OFS;
         h1o = ais_alarm_pkg::STS1_H1_OFS;
         h2g = ais_alarm_pkg::STS1_H2_GAP;
      end
      if (r.fmt == ais_alarm_pkg::FMT_AU3) begin
         nch = ais_alarm_pkg::CHANS;
      end

      for (int b = 0; b < 2; b++) begin
         byt = r.bus_d2[b];
         cp = r.c1_d2[b] ? 12'h000 :
              ((r.pos[b] == ais_alarm_pkg::POS_MAX) ? r.pos[b] : r.pos[b] + 12'h001);
         if (r.val_d2[b]) begin
            next_r.pos[b] = cp;
         end
         for (int n = 0; n < ais_alarm_pkg::CHANS; n++) begin
            chn = 12'(n);
            if (!r.aisen || n >= nch) begin
               next_r.ais[b][n] = 1'b0;
               next_r.set_cnt[b][n] = 2'h0;
               next_r.clr_cnt[b][n] = 2'h0;
            end else if (r.val_d2[b] && !r.owsel) begin
               // pointer bytes watched
               if (cp == h1o + chn) begin
                  next_r.h1_hold[b][n] = byt;
               end
               if (cp == h1o + h2g + chn) begin
                  if (r.h1_hold[b][n] == ais_alarm_pkg::ALL_ONES &&
                      byt == ais_alarm_pkg::ALL_ONES) begin
                     next_r.clr_cnt[b][n] = 2'h0;
                     if (r.set_cnt[b][n] != ais_alarm_pkg::AIS_FRAMES) begin
                        next_r.set_cnt[b][n] = r.set_cnt[b][n] + 2'h1;
                     end
                     if (r.set_cnt[b][n] + 2'h1 == ais_alarm_pkg::AIS_FRAMES) begin
                        next_r.ais[b][n] = 1'b1;
                     end
                  end else if (ndf_normal(r.h1_hold[b][n][7:4])) begin
                     next_r.set_cnt[b][n] = 2'h0;
                     if (r.clr_cnt[b][n] != ais_alarm_pkg::AIS_FRAMES) begin
                        next_r.clr_cnt[b][n] = r.clr_cnt[b][n] + 2'h1;
                     end
                     if (r.clr_cnt[b][n] + 2'h1 == ais_alarm_pkg::AIS_FRAMES) begin
                        next_r.ais[b][n] = 1'b0;
                     end
                  end else begin
                     next_r.set_cnt[b][n] = 2'h0;
                     next_r.clr_cnt[b][n] = 2'h0;
                  end
               end
            end else if (r.val_d2[b] && cp == e1o + chn) begin
               // order-wire majority vote, decided on each byte
               next_r.set_cnt[b][n] = 2'h0;
               next_r.clr_cnt[b][n] = 2'h0;
               next_r.ais[b][n] = (ones_of(byt) >= ais_alarm_pkg::E1_ONES_SET);
            end
         end
      end

      // alarm latching; a new event wins over a read clear in the same cycle
      next_r.prev = alarm_now;
      next_r.latch = r.latch & ~((access & ~pwrite_in) ? r.clr_sel : '0);
      next_r.latch = next_r.latch | event_hits(alarm_now, r.prev, r.transition_latch_enable, r.rise, r.fall);

      // hardware interrupt follows software indications while enabled
      next_r.irq = r.hwie & (|sw_ind);

      // apb: decode in setup, answer in the following access cycle
      next_r.pready = setup;
      next_r.pslverr = 1'b0; // error stands only in the access cycle
      if (setup) begin
         next_r.prdata = 32'h0000_0000;
         next_r.pslverr = 1'b0;
         next_r.clr_sel = '0;
         hit = 1'b1;
         if (paddr_in == reg_addr(ais_alarm_pkg::IDX_FORMAT)) begin
            next_r.prdata[ais_alarm_pkg::FMT_LSB +: 2] = r.fmt;
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_LATCH_CTL)) begin
            next_r.prdata[ais_alarm_pkg::TRANSITION_LATCH_ENABLE_BIT] = r.transition_latch_enable;
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_EDGE_CTL)) begin
            next_r.prdata[ais_alarm_pkg::RISE_BIT] = r.rise;
            next_r.prdata[ais_alarm_pkg::FALL_BIT] = r.fall;
            next_r.prdata[ais_alarm_pkg::REMOTE_FAIL_IRQ_ENABLE_BIT] = r.remote_fail_irq_enable;
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_AIS_CTL)) begin
            next_r.prdata[ais_alarm_pkg::AISEN_BIT] = r.aisen;
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_MODE_CTL)) begin
            next_r.prdata[ais_alarm_pkg::OWSEL_BIT] = r.owsel;
            next_r.prdata[ais_alarm_pkg::HWIE_BIT] = r.hwie;
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_FIFO_MASK)) begin
            next_r.prdata[7:0] = {r.tp_msk, r.rx_msk};
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_TXF_MASK)) begin
            next_r.prdata[7:0] = {r.tb_msk, r.ta_msk};
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_IRQ_IND)) begin
            next_r.prdata[6:0] = sw_ind;
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_PORT_MASK)) begin
            next_r.prdata[3:0] = r.port_msk;
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_A_AIS_EVT)) begin
            next_r.prdata[2:0] = r.latch[ais_alarm_pkg::AIS_BASE +: 3];
            next_r.clr_sel[ais_alarm_pkg::AIS_BASE +: 3] = r.latch[ais_alarm_pkg::AIS_BASE +: 3];
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_B_AIS_EVT)) begin
            next_r.prdata[2:0] = r.latch[ais_alarm_pkg::AIS_BASE + 3 +: 3];
            next_r.clr_sel[ais_alarm_pkg::AIS_BASE + 3 +: 3] =
               r.latch[ais_alarm_pkg::AIS_BASE + 3 +: 3];
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_A_AIS_LVL)) begin
            next_r.prdata[2:0] = r.ais[0];
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_B_AIS_LVL)) begin
            next_r.prdata[2:0] = r.ais[1];
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_A_AIS_MASK)) begin
            next_r.prdata[2:0] = r.a_ais_msk;
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_B_AIS_MASK)) begin
            next_r.prdata[2:0] = r.b_ais_msk;
         end else if (paddr_in == reg_addr(ais_alarm_pkg::IDX_RFI_EVT)) begin
            next_r.prdata[7:0] = r.latch[ais_alarm_pkg::RFI_BASE +: 8];
            next_r.clr_sel[ais_alarm_pkg::RFI_BASE +: 8] = r.latch[ais_alarm_pkg::RFI_BASE +: 8];
         end else begin
            hit = 1'b0;
         end
         // per-port common latch, cleared by the read
         for (int p = 0; p < ais_alarm_pkg::PORTS; p++) begin
            if (paddr_in == reg_addr(ais_alarm_pkg::IDX_PORT_LATCH[p])) begin
               hit = 1'b1;
               next_r.prdata[7:0] = {r.latch[p], ais_alarm_pkg::LATCH_RSVD, r.latch[4 + p],
                  r.latch[8 + p], r.latch[12 + p], r.latch[16 + p], r.latch[20 + p]};
               for (int k = 0; k < 6; k++) begin
                  next_r.clr_sel[k * 4 + p] = r.latch[k * 4 + p];
               end
            end
         end
         next_r.pslverr = ~hit;
      end

      // register writes take effect at the access edge
      if (access && pwrite_in && !r.pslverr) begin
         if (paddr_in == reg_addr(ais_alarm_pkg::IDX_FORMAT)) begin
            next_r.fmt = wd[ais_alarm_pkg::FMT_LSB +: 2];
         end
         if (paddr_in == reg_addr(ais_alarm_pkg::IDX_LATCH_CTL)) begin
            next_r.transition_latch_enable = wd[ais_alarm_pkg::TRANSITION_LATCH_ENABLE_BIT];
         end
         if (paddr_in == reg_addr(ais_alarm_pkg::IDX_EDGE_CTL)) begin
            next_r.rise = wd[ais_alarm_pkg::RISE_BIT];
            next_r.fall = wd[ais_alarm_pkg::FALL_BIT];
            next_r.remote_fail_irq_enable = wd[ais_alarm_pkg::REMOTE_FAIL_IRQ_ENABLE_BIT];
         end
         if (paddr_in == reg_addr(ais_alarm_pkg::IDX_AIS_CTL)) begin
            next_r.aisen = wd[ais_alarm_pkg::AISEN_BIT];
         end
         if (paddr_in == reg_addr(ais_alarm_pkg::IDX_MODE_CTL)) begin
            next_r.owsel = wd[ais_alarm_pkg::OWSEL_BIT];
            next_r.hwie = wd[ais_alarm_pkg::HWIE_BIT];
         end
         if (paddr_in == reg_addr(ais_alarm_pkg::IDX_FIFO_MASK)) begin
            next_r.rx_msk = wd[3:0];
            next_r.tp_msk = wd[7:4];
         end
         if (paddr_in == reg_addr(ais_alarm_pkg::IDX_TXF_MASK)) begin
            next_r.ta_msk = wd[3:0];
            next_r.tb_msk = wd[7:4];
         end
         if (paddr_in == reg_addr(ais_alarm_pkg::IDX_PORT_MASK)) begin
            next_r.port_msk = wd[3:0];
         end
         if (paddr_in == reg_addr(ais_alarm_pkg::IDX_A_AIS_MASK)) begin
            next_r.a_ais_msk = wd[2:0];
         end
         if (paddr_in == reg_addr(ais_alarm_pkg::IDX_B_AIS_MASK)) begin
            next_r.b_ais_msk = wd[2:0];
         end
      end
   end

   // one register bank for the whole state
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from flops
   assign prdata_out = r.prdata;
   assign pready_out = r.pready;
   assign pslverr_out = r.pslverr;
   assign a_bus_upstream_ais_out = r.ais[0];
   assign b_bus_upstream_ais_out = r.ais[1];
   assign irq_out = r.irq;
endmodule
`default_nettype wire

// >>> design/ais_alarm_pkg.sv
// constants, register map and field layout of the upstream alarm monitor
package ais_alarm_pkg;
   // register indices; the byte address is four times the index
   localparam logic [7:0] IDX_FORMAT = 8'h10;
   localparam logic [7:0] IDX_LATCH_CTL = 8'h11;
   localparam logic [7:0] IDX_EDGE_CTL = 8'h12;
   localparam logic [7:0] IDX_AIS_CTL = 8'h13;
   localparam logic [7:0] IDX_MODE_CTL = 8'h14;
   localparam logic [7:0] IDX_FIFO_MASK = 8'h18;
   localparam logic [7:0] IDX_TXF_MASK = 8'h19;
   localparam logic [7:0] IDX_IRQ_IND = 8'h20;
   localparam logic [7:0] IDX_PORT_MASK = 8'h21;
   localparam logic [7:0] IDX_A_AIS_EVT = 8'h22;
   localparam logic [7:0] IDX_A_AIS_LVL = 8'h23;
   localparam logic [7:0] IDX_A_AIS_MASK = 8'h24;
   localparam logic [7:0] IDX_B_AIS_MASK = 8'h25;
   localparam logic [7:0] IDX_B_AIS_EVT = 8'h26;
   localparam logic [7:0] IDX_B_AIS_LVL = 8'h27;
   localparam logic [7:0] IDX_RFI_EVT = 8'h2c;
   localparam logic [3:0][7:0] IDX_PORT_LATCH = {8'hd4, 8'ha4, 8'h74, 8'h44};
   // bit positions of control fields
   localparam int FMT_LSB = 6;
   localparam int TRANSITION_LATCH_ENABLE_BIT = 4;
   localparam int RISE_BIT = 5;
   localparam int FALL_BIT = 4;
   localparam int REMOTE_FAIL_IRQ_ENABLE_BIT = 3;
   localparam int AISEN_BIT = 7;
   localparam int OWSEL_BIT = 3;
   localparam int HWIE_BIT = 0;
   // bus format codes
   localparam logic [1:0] FMT_STS1 = 2'h0;
   localparam logic [1:0] FMT_AU3 = 2'h1;
   // reserved bits of a port latch read as 0 (bit 6) and 1 (bit 5)
   localparam logic [1:0] LATCH_RSVD = 2'h1;
   // byte distances from the c1 byte in each format
   localparam logic [11:0] STS3_E1_OFS = 12'h108;
   localparam logic [11:0] STS3_H1_OFS = 12'h324;
   localparam logic [11:0] STS3_H2_GAP = 12'h003;
   localparam logic [11:0] STS1_E1_OFS = 12'h058;
   localparam logic [11:0] STS1_H1_OFS = 12'h10c;
   localparam logic [11:0] STS1_H2_GAP = 12'h001;
   localparam logic [11:0] POS_MAX = 12'hfff;
   // detection figures
   localparam logic [1:0] AIS_FRAMES = 2'h3;
   localparam logic [3:0] E1_ONES_SET = 4'h5;
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam int CHANS = 3;
   localparam int PORTS = 4;
   // alarm vector layout: six port groups of four, six ais, eight rfi
   localparam int NPORT_ALM = 24;
   localparam int AIS_BASE = 24;
   localparam int RFI_BASE = 30;
   localparam int NALM = 38;
endpackage

// >>> test/drop_bus_model.sv
// drop bus source making framed bytes with a c1 marker and chosen overhead bytes
`timescale 1ns/1ps
`default_nettype none
module drop_bus_model (
   input wire logic clk_in, // system clock
   input wire logic run_in, // frames flow while high
   input wire logic [11:0] e1_pos_in, // first e1 position
   input wire logic [11:0] h1_pos_in, // first h1 position
   input wire logic [11:0] gap_in, // h2 distance from h1
   input wire logic [2:0][7:0] e1_in, // e1 byte per signal
   input wire logic [2:0][7:0] h1_in, // h1 byte per signal
   input wire logic [2:0][7:0] h2_in, // h2 byte per signal
   output logic [7:0] data_out, // drop byte
   output logic valid_out, // byte strobe
   output logic c1_out, // c1 marker
   output logic [15:0] frames_out // finished frames
);
   logic [11:0] pos = 12'h000;
   logic [7:0] b;
   initial begin
      frames_out = 16'h0000;
      valid_out = 1'b0;
      c1_out = 1'b0;
      data_out = 8'h00;
   end
   // one byte a clock; filler changes every byte, an idle bus toggles its last value
   always @(posedge clk_in) begin
      b = pos[7:0] ^ 8'h5a;
      for (int n = 0; n < 3; n++) if (pos == e1_pos_in + 12'(n)) b = e1_in[n];
      for (int n = 0; n < 3; n++) if (pos == h1_pos_in + 12'(n)) b = h1_in[n];
      for (int n = 0; n < 3; n++) if (pos == h1_pos_in + gap_in + 12'(n)) b = h2_in[n];
      valid_out <= run_in;
      c1_out <= run_in && pos == 12'h000;
      data_out <= run_in ? b : ~data_out;
      if (run_in) pos <= (pos == 12'h383) ? 12'h000 : pos + 12'h001;
      if (run_in && pos == 12'h383) frames_out <= frames_out + 16'h0001;
   end
endmodule
`default_nettype wire

// >>> test/ais_monitor_chk.sv
// port assertions for the upstream alarm monitor
`timescale 1ns/1ps
`default_nettype none
module ais_monitor_chk (
   input wire logic ref_clk_in, // system clock
   input wire logic rst_n_in, // async reset
   input wire logic psel_in, // apb select
   input wire logic penable_in, // apb enable
   input wire logic pwrite_in, // apb direction
   input wire logic [11:0] paddr_in, // apb address
   input wire logic [31:0] pwdata_in, // apb write data
   input wire logic [31:0] prdata_out, // apb read data
   input wire logic pready_out, // apb ready
   input wire logic pslverr_out, // apb error
   input wire logic [1:0] drop_valid_in, // byte strobes
   input wire logic [2:0] a_bus_upstream_ais_out, // a bus ais
   input wire logic [2:0] b_bus_upstream_ais_out, // b bus ais
   input wire logic irq_out // hardware interrupt
);
   logic [1:0] fmt;
   logic aisen;
   logic hwie;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   // shadow of control bits written over apb
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fmt <= 2'h0;
         aisen <= 1'b0;
         hwie <= 1'b0;
      end else if (psel_in && penable_in && pready_out && pwrite_in) begin
         if (paddr_in[9:2] == ais_alarm_pkg::IDX_FORMAT) fmt <= pwdata_in[7:6];
         if (paddr_in[9:2] == ais_alarm_pkg::IDX_AIS_CTL) aisen <= pwdata_in[7];
         if (paddr_in[9:2] == ais_alarm_pkg::IDX_MODE_CTL) hwie <= pwdata_in[0];
      end
   end
   ready_after_setup_a: assert property (psel_in && !penable_in |=> pready_out)
      else $error("pready missing after setup");
   ready_one_cycle_a: assert property (pready_out |=> !pready_out)
      else $error("pready longer than one cycle");
   error_with_ready_a: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
      else $error("pslverr without pready or with data");
   read_upper_zero_a: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   chan_exclude_a: assert property ((fmt != ais_alarm_pkg::FMT_AU3)[*4] |->
      a_bus_upstream_ais_out[2:1] == 2'h0 && b_bus_upstream_ais_out[2:1] == 2'h0)
      else $error("ais on excluded signal");
   ais_disable_a: assert property ((!aisen)[*4] |->
      a_bus_upstream_ais_out == 3'h0 && b_bus_upstream_ais_out == 3'h0)
      else $error("ais while detection disabled");
   ais_cause_a: assert property ($rose(a_bus_upstream_ais_out[0]) |->
      $past(drop_valid_in[0], 3)) else $error("ais rose without a byte");
   hw_irq_gate_a: assert property ((!hwie)[*3] |-> !irq_out)
      else $error("irq with hardware enable off");
   ais_seen_c: cover property ($rose(a_bus_upstream_ais_out[1]));
   irq_seen_c: cover property ($rose(irq_out));
   error_seen_c: cover property (pslverr_out);
endmodule
bind upstream_ais_alarm_monitor ais_monitor_chk chk (.ref_clk_in(ref_clk_in),
   .rst_n_in(rst_n_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
   .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .drop_valid_in(drop_valid_in),
   .a_bus_upstream_ais_out(a_bus_upstream_ais_out),
   .b_bus_upstream_ais_out(b_bus_upstream_ais_out), .irq_out(irq_out));
`default_nettype wire

// >>> test/upstream_ais_alarm_monitor_tb.sv
// self-checking bench for the upstream alarm monitor
`timescale 1ns/1ps
`default_nettype none
module upstream_ais_alarm_monitor_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, irq, vld, c1;
   logic [2:0] a_ais, b_ais;
   logic [5:0][3:0] alm = 24'h0;
   logic [3:0] a_rfi = 4'h0;
   logic [3:0] b_rfi = 4'h0;
   logic [11:0] e1_pos = ais_alarm_pkg::STS1_E1_OFS;
   logic [11:0] h1_pos = ais_alarm_pkg::STS1_H1_OFS;
   logic [11:0] gap = ais_alarm_pkg::STS1_H2_GAP;
   logic [2:0][7:0] e1 = 24'h0, h1 = 24'h0, h2 = 24'h0;
   logic [7:0] bus, rb;
   logic [15:0] frames;
   logic [3:0] new_data_flag_nibble [5] = '{4'h6, 4'he, 4'h2, 4'h4, 4'h7};
   logic [32:0] expq[$];
   int n_fail = 0;
   int samples_checked = 0;
   int seed = 32299;
   // 40 mhz clock
   always #12.5 clk = ~clk;
   drop_bus_model src (.clk_in(clk), .run_in(rst_n), .e1_pos_in(e1_pos), .h1_pos_in(h1_pos),
      .gap_in(gap), .e1_in(e1), .h1_in(h1), .h2_in(h2), .data_out(bus), .valid_out(vld),
      .c1_out(c1), .frames_out(frames));
   upstream_ais_alarm_monitor dut (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel),
      .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .drop_data_in({bus, bus}), .drop_valid_in({vld, vld}), .drop_c1_in({c1, c1}),
      .rx_fifo_error_in(alm[5]), .tx_fifo_a_error_in(alm[4]), .tx_fifo_b_error_in(alm[3]),
      .tributary_signal_loss_in(alm[2]), .tributary_clock_loss_in(alm[1]),
      .tributary_drop_ais_in(alm[0]), .a_rfi_in(a_rfi), .b_rfi_in(b_rfi),
      .a_bus_upstream_ais_out(a_ais), .b_bus_upstream_ais_out(b_ais), .irq_out(irq));
   task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic irq_is(input logic e);
      chk("irq", {32'h0, e}, {32'h0, irq});
   endtask
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                      input logic [32:0] e);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= {24'h0, d};
      if (!w) expq.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 33'h0);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b0, idx, 8'h00, {25'h0, d});
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // each finished read is compared with the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         chk("read", expq.pop_front(), {pslverr, prdata});
      end
   end
   // watchdog
   initial begin
      repeat (60000) @(posedge clk);
      n_fail++;
      end_of_test();
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      rd(8'h10, 8'h00);
      apb(1'b0, 8'h3f, 8'h00, {1'b1, 32'h0});
      wr(8'h13, 8'h80);
      @(frames);
      h1 <= {3{8'hff}};
      h2 <= {3{8'hff}};
      repeat (2) @(frames);
      rd(8'h23, 8'h00);
      @(frames);
      rd(8'h23, 8'h01);
      rd(8'h22, 8'h01);
      rb = {new_data_flag_nibble[$unsigned($random(seed)) % 5], 4'($random(seed))};
      h1 <= {3{rb}};
      h2 <= {3{8'($random(seed))}};
      repeat (2) @(frames);
      rd(8'h27, 8'h01);
      @(frames);
      rd(8'h27, 8'h00);
      $display("pointer test done");
      wr(8'h14, 8'h08);
      for (int i = 0; i < 6; i++) begin
         rb = (i == 0) ? 8'h1f : (i == 1) ? 8'hf0 : 8'($random(seed));
         e1 <= {3{rb}};
         @(frames);
         rd(8'h23, {7'h0, $countones(rb) >= 5});
      end
      wr(8'h10, 8'h40);
      e1_pos <= ais_alarm_pkg::STS3_E1_OFS;
      e1 <= {8'h00, 8'hff, 8'h00};
      repeat (2) @(frames);
      rd(8'h27, 8'h02);
      wr(8'h10, 8'h80);
      e1 <= {3{8'hff}};
      repeat (2) @(frames);
      rd(8'h23, 8'h01);
      wr(8'h13, 8'h00);
      repeat (4) @(posedge clk);
      chk("ais_a", 33'h0, {30'h0, a_ais});
      chk("ais_b", 33'h0, {30'h0, b_ais});
      rd(8'h27, 8'h00);
      $display("order wire test done");
      wr(8'h18, 8'h11);
      wr(8'h19, 8'h11);
      wr(8'h21, 8'h01);
      for (int h = 1; h >= 0; h--) begin
         wr(8'h14, 8'(h));
         alm <= {6{4'h1}};
         @(posedge clk);
         alm <= 24'h0;
         repeat (4) @(posedge clk);
         irq_is(h[0]);
         rd(8'h20, 8'h01);
         rd(8'h44, 8'hbf);
         repeat (3) @(posedge clk);
         irq_is(1'b0);
      end
      wr(8'h11, 8'h10);
      for (int m = 0; m < 4; m++) begin
         wr(8'h12, {2'h0, 2'(m), 4'h0});
         alm[0] <= 4'h1;
         repeat (4) @(posedge clk);
         rd(8'h44, {7'h10, m[1]});
         alm[0] <= 4'h0;
         repeat (4) @(posedge clk);
         rd(8'h44, {7'h10, m[0]});
      end
      $display("alarm test done");
      wr(8'h11, 8'h00);
      wr(8'h14, 8'h01);
      wr(8'h12, 8'h00);
      a_rfi <= 4'h1;
      repeat (4) @(posedge clk);
      irq_is(1'b0);
      a_rfi <= 4'h0;
      rd(8'h2c, 8'h01);
      wr(8'h12, 8'h08);
      b_rfi <= 4'h2;
      repeat (4) @(posedge clk);
      irq_is(1'b1);
      b_rfi <= 4'h0;
      rd(8'h2c, 8'h20);
      repeat (3) @(posedge clk);
      irq_is(1'b0);
      $display("remote failure test done");
      end_of_test();
   end
endmodule
`default_nettype wire
